/* hdl/pm_seq_host.sv */
// Host end: turns user requests into register writes.
// Assumes the sensor end shares sys_clk.
`timescale 1ns/10ps
`include "pm_seq_defs.svh"
module pm_seq_host (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  pm_seq_if.host          link,
  input  wire logic       reqForced,
  input  wire logic       reqNormal,
  input  wire logic       reqSleep,
  input  wire logic       reqStandby,
  input  wire logic [2:0] standbySel,
  output      logic       busy,
  output      logic       sampleReady
);
  logic [7:0] addrQ;
  logic [7:0] dataQ;
  logic       validQ;
  logic       readyQ;
  logic       forcedAltQ;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      validQ     <= 1'b0;
      addrQ      <= 8'h00;
      dataQ      <= 8'h00;
      forcedAltQ <= 1'b0;
    end else begin
      validQ <= 1'b0;
      if (!validQ) begin
        if (reqStandby) begin
          validQ <= 1'b1;
          addrQ  <= `CONFIG_ADDR;
          dataQ  <= {standbySel, 5'h00};
        end else if (reqForced) begin
          validQ <= 1'b1;
          addrQ  <= `CTRL_MEAS_ADDR;
          // Both forced codes are used in turn
          dataQ      <= {6'h00, (forcedAltQ ? `MODE_FORCED_B : `MODE_FORCED_A)};
          forcedAltQ <= !forcedAltQ;
        end else if (reqNormal) begin
          validQ <= 1'b1;
          addrQ  <= `CTRL_MEAS_ADDR;
          dataQ  <= {6'h00, `MODE_NORMAL};
        end else if (reqSleep) begin
          validQ <= 1'b1;
          addrQ  <= `CTRL_MEAS_ADDR;
          dataQ  <= {6'h00, `MODE_SLEEP};
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readyQ <= 1'b0;
    end else begin
      readyQ <= link.dataUpdated;
    end
  end

  assign link.wrValid = validQ;
  assign link.wrAddr  = addrQ;
  assign link.wrData  = dataQ;
  assign busy         = validQ || link.measActive;
  assign sampleReady  = readyQ;
endmodule : pm_seq_host

/* hdl/pm_seq_sensor.sv */
// Sensor end: mode and standby fields, measurement scheduling.
// Assumes writes arrive on the interface in the sys_clk domain.
`timescale 1ns/10ps
`include "pm_seq_defs.svh"

module pm_seq_sensor #(
  parameter int unsigned MEAS_CYCLES   = `MEAS_CYCLES,
  parameter int unsigned STANDBY_HALF  = `STANDBY_HALF_MS_US * `CLK_MHZ,
  parameter int unsigned STANDBY_UNIT  = `STANDBY_UNIT_US * `CLK_MHZ
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  pm_seq_if.sensor        link,
  output      logic [7:0] ctrlMeasQ,
  output      logic [7:0] configQ,
  output      logic       pendingQ
);
  pm_seq_pkg::seq_state_t stateQ;
  logic [31:0]            countQ;
  logic [1:0]             pendModeQ;
  logic                   dataUpdQ;
  logic                   ctrlWr;
  logic                   cfgWr;
  logic [1:0]             modeField;
  logic                   countDone;
  logic [31:0]            standbyLen;
  logic                   measEnd;
  logic [1:0]             modeAfter;

  // Standby length in cycles; 0.5 ms at 0, else 62.5 ms doubling each step
  function automatic logic [31:0] standby_cycles(input logic [2:0] sel);
    logic [31:0] r;
    r = 32'h0;
    if (sel == 3'h0) begin
      r = 32'(STANDBY_HALF);
    end else begin
      r = 32'(STANDBY_UNIT) << (sel - 3'h1);
    end
    return r;
  endfunction : standby_cycles

  assign ctrlWr     = link.wrValid && (link.wrAddr == `CTRL_MEAS_ADDR);
  assign cfgWr      = link.wrValid && (link.wrAddr == `CONFIG_ADDR);
  assign modeField  = ctrlMeasQ[`MODE_LSB +: `MODE_W];
  assign countDone  = (countQ == 32'h0);
  assign measEnd    = (stateQ == pm_seq_pkg::SEQ_MEASURE) && countDone;
  // Pending mode beats a new write
  assign modeAfter  = pendingQ ? pendModeQ : (ctrlWr ? link.wrData[`MODE_LSB +: `MODE_W] : modeField);
  assign standbyLen = standby_cycles(configQ[`STANDBY_LSB +: `STANDBY_W]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrlMeasQ <= 8'h00;
      pendingQ  <= 1'b0;
      pendModeQ <= 2'h0;
    end else if (measEnd) begin
      // Period ends here, so a same-edge write is not deferred
      if (ctrlWr) begin
        ctrlMeasQ[7:2] <= link.wrData[7:2];
      end
      if (pendingQ || ctrlWr) begin
        ctrlMeasQ[`MODE_LSB +: `MODE_W] <= modeAfter;
      end else if (modeField != `MODE_NORMAL) begin
        ctrlMeasQ[`MODE_LSB +: `MODE_W] <= `MODE_SLEEP;
      end
      pendingQ <= 1'b0;
    end else if (ctrlWr) begin
      if (stateQ == pm_seq_pkg::SEQ_MEASURE) begin
        if (!pendingQ) begin
          pendingQ  <= 1'b1;
          pendModeQ <= link.wrData[`MODE_LSB +: `MODE_W];
        end
        ctrlMeasQ[7:2] <= link.wrData[7:2];
      end else begin
        ctrlMeasQ <= link.wrData;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      configQ <= {`STANDBY_RESET, 5'h00};
    end else if (cfgWr) begin
      configQ <= link.wrData;
    end
  end

  // Measurement and standby scheduler
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stateQ   <= pm_seq_pkg::SEQ_IDLE;
      countQ   <= 32'h0;
      dataUpdQ <= 1'b0;
    end else begin
      dataUpdQ <= 1'b0;
      case (stateQ)
        pm_seq_pkg::SEQ_IDLE: begin
          if (modeField != `MODE_SLEEP) begin
            stateQ <= pm_seq_pkg::SEQ_MEASURE;
            countQ <= 32'(MEAS_CYCLES - 1);
          end
        end
        pm_seq_pkg::SEQ_MEASURE: begin
          if (countDone) begin
            dataUpdQ <= 1'b1;
            if (modeAfter == `MODE_NORMAL) begin
              stateQ <= pm_seq_pkg::SEQ_STANDBY;
              countQ <= standbyLen - 32'h1;
            end else begin
              stateQ <= pm_seq_pkg::SEQ_IDLE;
            end
          end else begin
            countQ <= countQ - 32'h1;
          end
        end
        pm_seq_pkg::SEQ_STANDBY: begin
          if (modeField != `MODE_NORMAL || (ctrlWr && link.wrData[`MODE_LSB +: `MODE_W] != `MODE_NORMAL)) begin
            stateQ <= pm_seq_pkg::SEQ_IDLE;
          end else if (countDone) begin
            stateQ <= pm_seq_pkg::SEQ_MEASURE;
            countQ <= 32'(MEAS_CYCLES - 1);
          end else begin
            countQ <= countQ - 32'h1;
          end
        end
        default: begin
          stateQ <= pm_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign link.measActive  = (stateQ == pm_seq_pkg::SEQ_MEASURE);
  assign link.dataUpdated = dataUpdQ;
  assign link.modeNow     = (modeField == `MODE_SLEEP)  ? 2'h0 :
                            (modeField == `MODE_NORMAL) ? 2'h3 : 2'h1;
endmodule : pm_seq_sensor

/* include/pm_seq_defs.svh */
// Constants for the measurement power-mode sequencer.
// Included by the package, both ends and the link checker.
`ifndef PM_SEQ_DEFS_SVH
`define PM_SEQ_DEFS_SVH
`define CTRL_MEAS_ADDR     8'hf4
`define CONFIG_ADDR        8'hf5
`define MODE_LSB           0
`define MODE_W             2
`define STANDBY_LSB        5
`define STANDBY_W          3
`define MODE_SLEEP         2'h0
`define MODE_FORCED_A      2'h1
`define MODE_FORCED_B      2'h2
`define MODE_NORMAL        2'h3
`define STANDBY_RESET      3'h0
`define CLK_MHZ            100
`define STANDBY_HALF_MS_US 500
`define STANDBY_UNIT_US    62500
`define MEAS_CYCLES        32'd6400
`define WRITE_GAP_CYCLES   4'h2
`endif

/* include/pm_seq_if.sv */
// Register write path between host and sensor sequencer.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface pm_seq_if (
  input wire logic sysClk
);
  logic       wrValid;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic       measActive;
  logic       dataUpdated;
  logic [1:0] modeNow;

  modport sensor (
    input  sysClk, wrValid, wrAddr, wrData,
    output measActive, dataUpdated, modeNow
  );
  modport host (
    input  sysClk, measActive, dataUpdated, modeNow,
    output wrValid, wrAddr, wrData
  );
endinterface : pm_seq_if

/* include/pm_seq_pkg.sv */
// Types for the sensor end of the power-mode sequencer.
// Assumes pm_seq_defs.svh is on the include path.
`include "pm_seq_defs.svh"
package pm_seq_pkg;
  typedef enum logic [1:0] {
    PM_SLEEP,
    PM_FORCED,
    PM_NORMAL
  } power_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_MEASURE,
    SEQ_STANDBY
  } seq_state_t;
endpackage : pm_seq_pkg

/* verification/measurement_power_mode_sequencer_bench.sv */
// Bench joining host and sensor ends over the link.
// Assumes shortened counts and host-issued writes only.
`timescale 1ns/10ps
module measurement_power_mode_sequencer_bench;
  localparam int unsigned MEAS = 20;
  localparam int unsigned HALF = 10;
  localparam int unsigned UNIT = 40;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  req     = 4'h0;
  logic [2:0]  sel     = 3'h0;
  logic [7:0]  ctrlMeasQ;
  logic [7:0]  configQ;
  logic        pendingQ;
  logic        busy;
  logic        sampleReady;
  logic [31:0] rnd     = 32'd73879;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          nDone = 0;
  int          nReady = 0;
  int          n;
  int          k;
  pm_seq_if link (.sysClk(sys_clk));
  pm_seq_sensor #(.MEAS_CYCLES(MEAS), .STANDBY_HALF(HALF), .STANDBY_UNIT(UNIT)) i_pm_seq_sensor (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link), .ctrlMeasQ(ctrlMeasQ), .configQ(configQ), .pendingQ(pendingQ));
  pm_seq_host i_pm_seq_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .reqForced(req[0]),
    .reqNormal(req[1]), .reqSleep(req[2]), .reqStandby(req[3]), .standbySel(sel), .busy(busy),
    .sampleReady(sampleReady));
  pm_seq_sva #(.MEAS_CYCLES(MEAS), .STANDBY_HALF(HALF), .STANDBY_UNIT(UNIT)) i_pm_seq_sva (.sysClk(sys_clk),
    .sys_rst(sys_rst), .wrValid(link.wrValid), .wrAddr(link.wrAddr), .wrData(link.wrData),
    .measActive(link.measActive), .dataUpdated(link.dataUpdated), .modeNow(link.modeNow));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (link.dataUpdated === 1'b1) nDone <= nDone + 1;
    if (sampleReady === 1'b1) nReady <= nReady + 1;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] sbLen(input logic [2:0] c);
    return (c == 3'h0) ? HALF : UNIT << (c - 3'h1);
  endfunction : sbLen
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction : xorshift
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk
  // Pulse lasts one cycle; the host latches it
  task automatic ask(input int r);
    @(posedge sys_clk);
    req[r] <= 1'b1;
    @(posedge sys_clk);
    req[r] <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : ask
  task automatic waitDone();
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (link.dataUpdated !== 1'b1 && n < 6000);
  endtask : waitDone
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (60) @(negedge sys_clk);
    chk("reset", 32'h0, {13'h0, configQ, ctrlMeasQ, pendingQ, link.modeNow});
    chk("sleep", 32'h0, nDone);
    for (int i = 0; i < 2; i++) begin
      k = nDone;
      ask(0);
      repeat (MEAS + 20) @(negedge sys_clk);
      chk("forced", k + 1, nDone);
      chk("fallback", 32'h0, 32'(link.modeNow));
    end
    rnd = xorshift(rnd);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      sel <= rnd[2:0] + 3'(i);
      ask(3);
      chk("standby", 32'(sel), 32'(configQ[7:5]));
      ask(1);
      waitDone();
      waitDone();
      chk("period", MEAS + sbLen(sel), n);
      waitDone();
      chk("again", MEAS + sbLen(sel), n);
      ask(2);
      repeat (MEAS + 10) @(negedge sys_clk);
      chk("stopped", 32'h0, 32'(link.modeNow));
    end
    ask(1);
    ask(2);
    chk("pending", 32'h1, 32'(pendingQ));
    chk("held", 32'h3, 32'(link.modeNow));
    chk("busy", 32'h1, 32'(busy));
    ask(0);
    repeat (MEAS + 10) @(negedge sys_clk);
    k = nDone;
    repeat (3 * MEAS) @(negedge sys_clk);
    chk("dropped", {30'h0, 2'h0}, 32'(link.modeNow));
    chk("quiet", k, nDone);
    chk("ready", nDone, nReady);
    chk("idle", 32'h0, 32'(busy));
    tally_and_finish();
  end
endmodule : measurement_power_mode_sequencer_bench

/* verification/pm_seq_sva.sv */
// Link checker for the power-mode sequencer.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/10ps
`include "pm_seq_defs.svh"
module pm_seq_sva #(
  parameter int unsigned MEAS_CYCLES  = `MEAS_CYCLES,
  parameter int unsigned STANDBY_HALF = `STANDBY_HALF_MS_US * `CLK_MHZ,
  parameter int unsigned STANDBY_UNIT = `STANDBY_UNIT_US * `CLK_MHZ
) (
  input wire logic       sysClk,
  input wire logic       sys_rst,
  input wire logic       wrValid,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic       measActive,
  input wire logic       dataUpdated,
  input wire logic [1:0] modeNow
);
  logic [31:0] hiQ;
  logic [31:0] loQ;
  logic [2:0]  sbQ;
  logic        cleanQ;
  wire         modeWr = wrValid && wrAddr == `CTRL_MEAS_ADDR && wrData[1:0] != `MODE_SLEEP;
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sysClk) hiQ <= measActive ? hiQ + 32'h1 : 32'h0;
  always_ff @(posedge sysClk) loQ <= measActive ? 32'h0 : loQ + 32'h1;
  // Any write spoils a standby gap, so only clean gaps are timed
  always_ff @(posedge sysClk) begin
    if (sys_rst) begin
      sbQ    <= 3'h0;
      cleanQ <= 1'b0;
    end else begin
      if (wrValid && wrAddr == `CONFIG_ADDR) sbQ <= wrData[7:5];
      cleanQ <= measActive || (cleanQ && !wrValid && modeNow == 2'h3);
    end
  end
  function automatic logic [31:0] sbLen(input logic [2:0] c);
    return (c == 3'h0) ? STANDBY_HALF : STANDBY_UNIT << (c - 3'h1);
  endfunction : sbLen
  sequence donePulse;
    dataUpdated ##1 !dataUpdated;
  endsequence
  sequence twoMeas;
    measActive ##1 measActive;
  endsequence
  AST_RESET_SLEEP: assert property (disable iff (1'b0) sys_rst |=> modeNow == 2'h0 && !measActive)
    else $error("not asleep after reset");
  AST_LAUNCH: assert property (!measActive && modeNow == 2'h0 && modeWr
    |=> modeNow == ($past(wrData[1:0]) == 2'h3 ? 2'h3 : 2'h1) ##1 measActive) else $error("bad mode launch");
  AST_MEAS_LEN: assert property ($fell(measActive) |-> hiQ == MEAS_CYCLES)
    else $error("measurement length wrong");
  AST_DONE: assert property ($fell(measActive) |-> donePulse)
    else $error("no result pulse");
  AST_ONLY_AT_END: assert property (dataUpdated |-> $fell(measActive))
    else $error("result pulse off the end");
  AST_NO_SLEEP_MEAS: assert property ($rose(measActive) |-> $past(modeNow) != 2'h0)
    else $error("conversion in sleep");
  AST_DEFER: assert property (twoMeas |-> $stable(modeNow))
    else $error("mode changed mid measurement");
  AST_STANDBY: assert property ($rose(measActive) && cleanQ && modeNow == 2'h3 |-> loQ == sbLen(sbQ))
    else $error("standby length wrong");
endmodule : pm_seq_sva
